// [rtl/obcd_option_decode.sv]
// Behaviour
// - With the low-speed permission bit at 0 a CPU clock request for the low-speed RC oscillator is refused.
// - The independent watchdog hardware-start bit at 1 starts that watchdog at load, at 0 software starts it.
// - The window watchdog hardware-start bit at 1 starts that watchdog at load, at 0 software starts it.
// - With the window watchdog running and the halt-reset bit at 1, entering halt raises a reset request.
// - The external clock select bit picks a crystal at 0 and a direct clock on the input pin at 1.
// - The wakeup clock select bit picks the low-speed oscillator at 0, the prescaled external clock at 1.
// - The wakeup prescale codes 00 to 11 divide 24, 16, 8 and 4 MHz down to 128 kHz.
// - The settle field codes 0x00, 0xb4, 0xd2, 0xe1 wait 2048, 128, 8 and half an oscillator cycle.
// - The flash wait bit inserts no wait state at 0 and exactly one at 1 on every memory read.
// - Eight remap bits each move a group of alternate functions to their other pins when set.
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "obcd_defines.svh"
module obcd_option_decode
    import obcd_pkg::*;
#(
    parameter bit PKG_44PIN = 1'b0 // Package has the fourth remap function
) (
    input  wire logic        core_clk,         // System clock, 50 MHz
    input  wire logic        rst,              // System reset, sync, active high
    input  wire logic        porRst,           // Power-on reset, clears stored bytes
    input  wire logic        hsel,             // AHB select
    input  wire logic [31:0] haddr,            // AHB address
    input  wire logic [1:0]  htrans,           // AHB transfer type
    input  wire logic        hwrite,           // AHB write
    input  wire logic [2:0]  hsize,            // AHB size
    input  wire logic [31:0] hwdata,           // AHB write data
    input  wire logic        hready,           // AHB ready in
    output logic      [31:0] hrdata,           // AHB read data
    output logic             hreadyout,        // AHB ready out
    output logic             hresp,            // AHB response
    input  wire logic        cpuClkReqValid,   // CPU clock switch request
    input  wire logic [1:0]  cpuClkReq,        // Requested CPU clock source
    input  wire logic        iwdSwStart,       // Software start, independent watchdog
    input  wire logic        wwdSwStart,       // Software start, window watchdog
    input  wire logic        haltEnter,        // CPU enters halt
    input  wire logic        oscEdge,          // One external oscillator edge
    input  wire logic        memReadStart,     // Flash or EEPROM read begins
    output logic             lowSpeedOscCpuAllow, // Low-speed oscillator usable as CPU clock
    output logic [1:0]       cpuClkSrc,        // Current CPU clock source
    output logic             cpuClkRefused,    // Request refused pulse
    output logic             indepWatchdogRun, // Independent watchdog running
    output logic             windowWatchdogRun, // Window watchdog running
    output logic             haltResetReq,     // Reset request on halt pulse
    output logic             extClockSelect,   // 1 direct clock, 0 crystal
    output logic             wakeupClockSelect, // 1 prescaled external, 0 low-speed
    output logic [1:0]       wakeupClockPrescale, // Wakeup prescale code
    output logic [9:0]       wakeupDivQuarter, // Wakeup divide ratio times four
    output logic             crystalStable,    // External oscillator settled
    output logic             flashWaitSelect,  // One flash wait state
    output logic             memReadAck,       // Memory read data ready pulse
    output logic [7:0]       pinRemap,         // Alternate function remap bits
    output logic             configLoaded      // Holding registers valid
);
    obcd_st_t      st;
    obcd_st_t      next_st;
    obcd_settle_if sif ();

    // ---------------------------------------------
    // Crystal settle timer
    // ---------------------------------------------
    obcd_settle_timer u_settle (
        .core_clk (core_clk),
        .rst      (rst),
        .sif      (sif.timer)
    );

    assign sif.start    = st.settleStart;
    assign sif.code     = st.settleCode;
    assign sif.edgeTick = oscEdge;

    // ---------------------------------------------
    // Bus decode helpers
    // ---------------------------------------------
    logic       addrTake;
    logic [7:0] rdAddr;
    logic [7:0] remapIn;
    logic [7:0] rdByte;

    assign addrTake = hsel && hready && htrans[1] && (hsize == 3'b010);
    assign rdAddr   = haddr[7:0];
    // Non-44-pin parts never see the fourth remap bit set
    assign remapIn  = PKG_44PIN ? hwdata[7:0]
                    : (hwdata[7:0] & ~(8'h01 << `OBCD_REMAP_FOUR));

    always_comb begin
        next_st               = st;
        next_st.cpuClkRefused = 1'b0;
        next_st.haltResetReq  = 1'b0;
        next_st.settleStart   = 1'b0;
        next_st.memAck        = 1'b0;
        rdByte                = 8'h00;

        // ---------------------------------------------
        // Data phase of a write into stored bytes
        // ---------------------------------------------
        if (st.dValid && st.dWrite) begin
            unique case (st.dAddr)
                `OBCD_OFF_CLK_WD:     next_st.optClkWd     = hwdata[7:0];
                `OBCD_OFF_EXT_WAKE:   next_st.optExtWake   = hwdata[7:0];
                `OBCD_OFF_SETTLE:     next_st.optSettle    = hwdata[7:0];
                `OBCD_OFF_FLASH_WAIT: next_st.optFlashWait = hwdata[7:0];
                `OBCD_OFF_REMAP:      next_st.optRemap     = remapIn;
                default: ;
            endcase
        end

        // ---------------------------------------------
        // Address phase; read data forwards a pending write
        // ---------------------------------------------
        next_st.dValid = addrTake;
        next_st.dWrite = hwrite;
        next_st.dAddr  = rdAddr;
        if (addrTake && !hwrite) begin
            unique case (rdAddr)
                `OBCD_OFF_CLK_WD:     rdByte = next_st.optClkWd;
                `OBCD_OFF_EXT_WAKE:   rdByte = next_st.optExtWake;
                `OBCD_OFF_SETTLE:     rdByte = next_st.optSettle;
                `OBCD_OFF_FLASH_WAIT: rdByte = next_st.optFlashWait;
                `OBCD_OFF_REMAP:      rdByte = next_st.optRemap;
                `OBCD_OFF_STATUS: begin
                    rdByte = {1'b0, sif.reservedCode, st.cpuClkSrc, st.wwdRun,
                              st.iwdRun, sif.stable, st.loaded};
                end
                default: rdByte = 8'h00;
            endcase
            next_st.hrdata = {24'h000000, rdByte};
        end

        // ---------------------------------------------
        // Load holding registers once after reset
        // ---------------------------------------------
        unique case (st.phase)
            OBCD_LOAD: begin
                // Outputs hold these copies until the next reset
                next_st.slowAllow  = st.optClkWd[`OBCD_BIT_SLOW_ALLOW];
                next_st.iwdHw      = st.optClkWd[`OBCD_BIT_IWD_HW];
                next_st.wwdHw      = st.optClkWd[`OBCD_BIT_WWD_HW];
                next_st.wwdHalt    = st.optClkWd[`OBCD_BIT_WWD_HALT];
                next_st.extSel     = st.optExtWake[`OBCD_BIT_EXT_SEL];
                next_st.wakeSel    = st.optExtWake[`OBCD_BIT_WAKE_SEL];
                next_st.wakePre    = st.optExtWake[1:0];
                next_st.flashWait  = st.optFlashWait[`OBCD_BIT_WAIT];
                next_st.remap      = st.optRemap;
                next_st.settleCode = st.optSettle;
                next_st.settleStart = 1'b1;
                // Hardware-start watchdogs run without software action
                next_st.iwdRun     = st.optClkWd[`OBCD_BIT_IWD_HW];
                next_st.wwdRun     = st.optClkWd[`OBCD_BIT_WWD_HW];
                unique case (st.optExtWake[1:0])
                    2'b00: next_st.wakeDivQ = `OBCD_WAKE_DIVQ_24M;
                    2'b01: next_st.wakeDivQ = `OBCD_WAKE_DIVQ_16M;
                    2'b10: next_st.wakeDivQ = `OBCD_WAKE_DIVQ_8M;
                    2'b11: next_st.wakeDivQ = `OBCD_WAKE_DIVQ_4M;
                endcase
                next_st.loaded = 1'b1;
                next_st.phase  = OBCD_RUN;
            end
            OBCD_RUN: begin
                if (iwdSwStart && !st.iwdHw) begin
                    next_st.iwdRun = 1'b1;
                end
                if (wwdSwStart && !st.wwdHw) begin
                    next_st.wwdRun = 1'b1;
                end
                if (haltEnter && st.wwdRun && st.wwdHalt) begin
                    next_st.haltResetReq = 1'b1;
                end
                if (cpuClkReqValid) begin
                    if (cpuClkReq == OBCD_SRC_SLOW && !st.slowAllow) begin
                        next_st.cpuClkRefused = 1'b1;
                    end else if (cpuClkReq <= OBCD_SRC_SLOW) begin
                        next_st.cpuClkSrc = obcd_clk_src_t'(cpuClkReq);
                    end else begin
                        next_st.cpuClkRefused = 1'b1;
                    end
                end
            end
        endcase

        // ---------------------------------------------
        // Memory read wait states
        // ---------------------------------------------
        if (st.memBusy) begin
            if (st.memWait) begin
                next_st.memWait = 1'b0;
            end else begin
                next_st.memBusy = 1'b0;
                next_st.memAck  = 1'b1;
            end
        end else if (memReadStart && st.loaded) begin
            // One extra cycle only when the wait bit is set
            next_st.memBusy = 1'b1;
            next_st.memWait = st.flashWait;
        end

        // ---------------------------------------------
        // Resets; stored bytes survive system reset
        // ---------------------------------------------
        if (rst || porRst) begin
            next_st.phase         = OBCD_LOAD;
            next_st.dValid        = 1'b0;
            next_st.dWrite        = 1'b0;
            next_st.dAddr         = 8'h00;
            next_st.hrdata        = 32'h00000000;
            next_st.hreadyout     = 1'b1;
            next_st.slowAllow     = 1'b0;
            next_st.iwdHw         = 1'b0;
            next_st.wwdHw         = 1'b0;
            next_st.wwdHalt       = 1'b0;
            next_st.extSel        = 1'b0;
            next_st.wakeSel       = 1'b0;
            next_st.wakePre       = 2'b00;
            next_st.wakeDivQ      = `OBCD_WAKE_DIVQ_24M;
            next_st.flashWait     = 1'b0;
            next_st.remap         = 8'h00;
            next_st.settleCode    = `OBCD_RST_SETTLE;
            next_st.settleStart   = 1'b0;
            next_st.iwdRun        = 1'b0;
            next_st.wwdRun        = 1'b0;
            next_st.haltResetReq  = 1'b0;
            next_st.cpuClkSrc     = OBCD_SRC_INT;
            next_st.cpuClkRefused = 1'b0;
            next_st.loaded        = 1'b0;
            next_st.memBusy       = 1'b0;
            next_st.memWait       = 1'b0;
            next_st.memAck        = 1'b0;
        end
        if (porRst) begin
            next_st.optClkWd     = `OBCD_RST_CLK_WD;
            next_st.optExtWake   = `OBCD_RST_EXT_WAKE;
            next_st.optSettle    = `OBCD_RST_SETTLE;
            next_st.optFlashWait = `OBCD_RST_FLASH_WAIT;
            next_st.optRemap     = `OBCD_RST_REMAP;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    // ---------------------------------------------
    // Outputs, all taken from state flops except hresp, tied to 0
    // ---------------------------------------------
    assign hrdata              = st.hrdata;
    assign hreadyout           = st.hreadyout;
    assign hresp               = 1'b0;
    assign lowSpeedOscCpuAllow = st.slowAllow;
    assign cpuClkSrc           = st.cpuClkSrc;
    assign cpuClkRefused       = st.cpuClkRefused;
    assign indepWatchdogRun    = st.iwdRun;
    assign windowWatchdogRun   = st.wwdRun;
    assign haltResetReq        = st.haltResetReq;
    assign extClockSelect      = st.extSel;
    assign wakeupClockSelect   = st.wakeSel;
    assign wakeupClockPrescale = st.wakePre;
    assign wakeupDivQuarter    = st.wakeDivQ;
    assign crystalStable       = sif.stable;
    assign flashWaitSelect     = st.flashWait;
    assign memReadAck          = st.memAck;
    assign pinRemap            = st.remap;
    assign configLoaded        = st.loaded;
endmodule // obcd_option_decode

// [rtl/obcd_defines.svh]
`ifndef OBCD_DEFINES_SVH
`define OBCD_DEFINES_SVH

// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define OBCD_OFF_CLK_WD      8'h00
`define OBCD_OFF_EXT_WAKE    8'h04
`define OBCD_OFF_SETTLE      8'h08
`define OBCD_OFF_RESERVED    8'h0c
`define OBCD_OFF_FLASH_WAIT  8'h10
`define OBCD_OFF_REMAP       8'h14
`define OBCD_OFF_STATUS      8'h18

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define OBCD_BIT_SLOW_ALLOW  3
`define OBCD_BIT_IWD_HW      2
`define OBCD_BIT_WWD_HW      1
`define OBCD_BIT_WWD_HALT    0
`define OBCD_BIT_EXT_SEL     3
`define OBCD_BIT_WAKE_SEL    2
`define OBCD_BIT_WAIT        0
`define OBCD_REMAP_FOUR      4

// ---------------------------------------------
// Reset values of the stored option bytes
// ---------------------------------------------
`define OBCD_RST_CLK_WD      8'h00
`define OBCD_RST_EXT_WAKE    8'h00
`define OBCD_RST_SETTLE      8'h00
`define OBCD_RST_FLASH_WAIT  8'h00
`define OBCD_RST_REMAP       8'h00

// ---------------------------------------------
// Crystal settle codes and counts in half cycles
// ---------------------------------------------
`define OBCD_SETTLE_C2048    8'h00
`define OBCD_SETTLE_C128     8'hb4
`define OBCD_SETTLE_C8       8'hd2
`define OBCD_SETTLE_CHALF    8'he1
`define OBCD_HALVES_2048     13'h1000
`define OBCD_HALVES_128      13'h0100
`define OBCD_HALVES_8        13'h0010
`define OBCD_HALVES_HALF     13'h0001

// ---------------------------------------------
// Wakeup divide ratios to 128 kHz, in quarters
// ---------------------------------------------
`define OBCD_WAKE_DIVQ_24M   10'h2ee
`define OBCD_WAKE_DIVQ_16M   10'h1f4
`define OBCD_WAKE_DIVQ_8M    10'h0fa
`define OBCD_WAKE_DIVQ_4M    10'h07d

`endif

// [rtl/obcd_pkg.sv]
package obcd_pkg;

    typedef enum logic [1:0] {
        OBCD_SRC_INT,
        OBCD_SRC_EXT,
        OBCD_SRC_SLOW
    } obcd_clk_src_t;

    typedef enum logic {
        OBCD_LOAD,
        OBCD_RUN
    } obcd_phase_t;

    typedef struct packed {
        logic [12:0] count;
        logic        busy;
        logic        stable;
        logic        reservedCode;
    } obcd_settle_st_t;

    typedef struct packed {
        logic [7:0]    optClkWd;
        logic [7:0]    optExtWake;
        logic [7:0]    optSettle;
        logic [7:0]    optFlashWait;
        logic [7:0]    optRemap;
        obcd_phase_t   phase;
        logic          dValid;
        logic          dWrite;
        logic [7:0]    dAddr;
        logic [31:0]   hrdata;
        logic          hreadyout;
        logic          slowAllow;
        logic          iwdHw;
        logic          wwdHw;
        logic          wwdHalt;
        logic          extSel;
        logic          wakeSel;
        logic [1:0]    wakePre;
        logic [9:0]    wakeDivQ;
        logic          flashWait;
        logic [7:0]    remap;
        logic [7:0]    settleCode;
        logic          settleStart;
        logic          iwdRun;
        logic          wwdRun;
        logic          haltResetReq;
        obcd_clk_src_t cpuClkSrc;
        logic          cpuClkRefused;
        logic          loaded;
        logic          memBusy;
        logic          memWait;
        logic          memAck;
    } obcd_st_t;

endpackage

// [rtl/obcd_settle_if.sv]
`timescale 1ns/1ns
interface obcd_settle_if;
    logic       start;
    logic [7:0] code;
    logic       edgeTick;
    logic       stable;
    logic       reservedCode;

    modport ctrl  (output start, code, edgeTick, input stable, reservedCode);
    modport timer (input start, code, edgeTick, output stable, reservedCode);
endinterface

// [rtl/obcd_settle_timer.sv]
`timescale 1ns/1ns
`include "obcd_defines.svh"
module obcd_settle_timer
    import obcd_pkg::*;
(
    input  wire logic    core_clk, // System clock
    input  wire logic    rst,      // Synchronous reset
    obcd_settle_if.timer sif       // Settle control
);
    obcd_settle_st_t st;
    obcd_settle_st_t next_st;
    logic [12:0]     target;
    logic            unknown;

    always_comb begin
        unknown = 1'b0;
        unique case (sif.code)
            `OBCD_SETTLE_C2048: target = `OBCD_HALVES_2048;
            `OBCD_SETTLE_C128:  target = `OBCD_HALVES_128;
            `OBCD_SETTLE_C8:    target = `OBCD_HALVES_8;
            `OBCD_SETTLE_CHALF: target = `OBCD_HALVES_HALF;
            default: begin
                // Unknown codes fall back to the longest, safest wait
                target  = `OBCD_HALVES_2048;
                unknown = 1'b1;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        if (sif.start) begin
            next_st.count        = '0;
            next_st.busy         = 1'b1;
            next_st.stable       = 1'b0;
            next_st.reservedCode = unknown;
        end else if (st.busy && sif.edgeTick) begin
            // Each tick is one oscillator edge, so half a cycle
            next_st.count = st.count + 13'h0001;
            if (st.count + 13'h0001 == target) begin
                next_st.busy   = 1'b0;
                next_st.stable = 1'b1;
            end
        end
        if (rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign sif.stable       = st.stable;
    assign sif.reservedCode = st.reservedCode;
endmodule // obcd_settle_timer

// [tb/obcd_option_decode_sva.sv]
`timescale 1ns/1ns
module obcd_option_decode_sva
    import obcd_pkg::*;
(
    input wire logic       core_clk,            // Clock
    input wire logic       rst,                 // Reset
    input wire logic       porRst,              // Power-on reset
    input wire logic       cpuClkReqValid,      // Clock request
    input wire logic [1:0] cpuClkReq,           // Requested source
    input wire logic       haltEnter,           // Halt entry
    input wire logic       memReadStart,        // Memory read start
    input wire logic       lowSpeedOscCpuAllow, // Low-speed permit
    input wire logic [1:0] cpuClkSrc,           // Clock source
    input wire logic       cpuClkRefused,       // Refused pulse
    input wire logic       indepWatchdogRun,    // Watchdog run
    input wire logic       windowWatchdogRun,   // Window watchdog run
    input wire logic       haltResetReq,        // Halt reset pulse
    input wire logic [1:0] wakeupClockPrescale, // Prescale code
    input wire logic [9:0] wakeupDivQuarter,    // Divide ratio x4
    input wire logic       crystalStable,       // Settled flag
    input wire logic       flashWaitSelect,     // Wait state
    input wire logic       memReadAck,          // Read ack pulse
    input wire logic [7:0] pinRemap,            // Remap bits
    input wire logic       configLoaded         // Loaded flag
);
    // ---------------------------------------------
    // Properties
    // ---------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst || porRst);

    a_slow_refused:
        assert property (cpuClkReqValid && configLoaded && cpuClkReq == 2'h2 && !lowSpeedOscCpuAllow
            |=> cpuClkRefused && cpuClkSrc != 2'h2) else $error("low-speed request not refused");
    a_slow_granted:
        assert property (cpuClkReqValid && configLoaded && cpuClkReq == 2'h2 && lowSpeedOscCpuAllow
            |=> cpuClkSrc == 2'h2 && !cpuClkRefused) else $error("low-speed request not granted");
    a_iwd_sticky:
        assert property (indepWatchdogRun |=> indepWatchdogRun) else $error("watchdog stopped");
    a_wwd_sticky:
        assert property (windowWatchdogRun |=> windowWatchdogRun) else $error("window watchdog stopped");
    a_halt_cause:
        assert property (haltResetReq |-> $past(haltEnter) && $past(windowWatchdogRun))
            else $error("halt reset without cause");
    a_wake_ratio:
        assert property (wakeupDivQuarter == (wakeupClockPrescale == 2'h0 ? 10'h2ee : wakeupClockPrescale == 2'h1
            ? 10'h1f4 : wakeupClockPrescale == 2'h2 ? 10'h0fa : 10'h07d)) else $error("wrong wakeup ratio");
    a_mem_latency:
        assert property (memReadAck |-> ($past(memReadStart, 2) && !flashWaitSelect)
            || ($past(memReadStart, 3) && flashWaitSelect)) else $error("memory ack latency wrong");
    a_config_hold:
        assert property (configLoaded && $past(configLoaded) |-> $stable(pinRemap) && $stable(flashWaitSelect)
            && $stable(lowSpeedOscCpuAllow)) else $error("decoded option changed without reset");
    a_settle_hold:
        assert property (crystalStable |=> crystalStable) else $error("crystal stable dropped");

    c_refused: cover property (cpuClkRefused);
    c_halt: cover property (haltResetReq);
    c_settled: cover property ($rose(crystalStable));
endmodule // obcd_option_decode_sva

bind obcd_option_decode obcd_option_decode_sva u_obcd_option_decode_sva (.*);

// [tb/test_obcd_option_decode.sv]
`timescale 1ns/1ns
module test_obcd_option_decode;
    import obcd_pkg::*;
    // ---------------------------------------------
    // Signals
    // ---------------------------------------------
    logic        core_clk = 1'h0, rst = 1'h1, porRst = 1'h1, hsel = 1'h0, hwrite = 1'h0, hready;
    logic        cpuClkReqValid = 1'h0, iwdSwStart = 1'h0, wwdSwStart = 1'h0, haltEnter = 1'h0;
    logic        oscEdge = 1'h0, memReadStart = 1'h0, hreadyout, hresp, lowSpeedOscCpuAllow, cpuClkRefused;
    logic        indepWatchdogRun, windowWatchdogRun, haltResetReq, extClockSelect, wakeupClockSelect;
    logic        crystalStable, flashWaitSelect, memReadAck, configLoaded;
    logic [1:0]  htrans = 2'h0, cpuClkReq = 2'h0, cpuClkSrc, wakeupClockPrescale;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  pinRemap;
    logic [9:0]  wakeupDivQuarter;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0]  settleCode [5] = '{8'h00, 8'hb4, 8'hd2, 8'he1, 8'h55};
    int          settleN [5] = '{13'h1000, 13'h0100, 13'h0010, 13'h0001, 13'h1000};
    logic [9:0]  divQ [4] = '{10'h2ee, 10'h1f4, 10'h0fa, 10'h07d};
    int          errors = 0, total_checks = 0, cycles = 0;

    assign hready = hreadyout;
    always #10 core_clk = ~core_clk;

    obcd_option_decode u_obcd_option_decode (.*);

    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        hsel   <= 1'h1;
        haddr  <= {24'h0, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge core_clk);
        while (hready !== 1'h1) @(posedge core_clk);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge core_clk);
        while (hready !== 1'h1) @(posedge core_clk);
        rd = hrdata;
    endtask

    // Decoded outputs only follow the stored bytes at the load after a reset
    task reset_pulse(input logic por);
        rst    <= 1'h1;
        porRst <= por;
        repeat (2) @(posedge core_clk);
        rst    <= 1'h0;
        porRst <= 1'h0;
        repeat (2) @(posedge core_clk);
    endtask

    task clk_req(input logic [1:0] src, input logic refuse);
        cpuClkReqValid <= 1'h1;
        cpuClkReq      <= src;
        @(posedge core_clk);
        cpuClkReqValid <= 1'h0;
        @(posedge core_clk);
        chk(cpuClkRefused, refuse);
    endtask

    task halt_check(input logic exp);
        haltEnter <= 1'h1;
        @(posedge core_clk);
        haltEnter <= 1'h0;
        @(posedge core_clk);
        chk(haltResetReq, exp);
    endtask

    task mem_read(input int n);
        memReadStart <= 1'h1;
        @(posedge core_clk);
        memReadStart <= 1'h0;
        for (int k = 1; k <= n; k++) begin
            @(posedge core_clk);
            chk(memReadAck, k == n);
        end
    endtask

    task osc_pulses(input int n);
        repeat (n) begin
            oscEdge <= 1'h1;
            @(posedge core_clk);
            oscEdge <= 1'h0;
            @(posedge core_clk);
        end
    endtask

    // ---------------------------------------------
    // Sequence
    // ---------------------------------------------
    initial begin
        reset_pulse(1'h1);
        chk(configLoaded, 1'h1);
        chk(indepWatchdogRun, 1'h0);
        chk(windowWatchdogRun, 1'h0);
        clk_req(2'h2, 1'h1);
        iwdSwStart <= 1'h1;
        wwdSwStart <= 1'h1;
        @(posedge core_clk);
        iwdSwStart <= 1'h0;
        wwdSwStart <= 1'h0;
        @(posedge core_clk);
        chk(indepWatchdogRun, 1'h1);
        chk(windowWatchdogRun, 1'h1);
        halt_check(1'h0);
        mem_read(2);
        bus(1'h1, 8'h00, 32'h0000000f);
        bus(1'h1, 8'h10, 32'h00000001);
        bus(1'h1, 8'h14, 32'h000000ff);
        bus(1'h0, 8'h14, 32'h0);
        chk(rd, 32'h000000ef);
        chk({hreadyout, hresp}, 32'h2);
        bus(1'h0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        bus(1'h0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk(pinRemap, 8'h00);
        chk(flashWaitSelect, 1'h0);
        reset_pulse(1'h0);
        chk(lowSpeedOscCpuAllow, 1'h1);
        chk(indepWatchdogRun, 1'h1);
        chk(windowWatchdogRun, 1'h1);
        chk(flashWaitSelect, 1'h1);
        chk(pinRemap, 8'hef);
        clk_req(2'h2, 1'h0);
        chk(cpuClkSrc, 2'h2);
        clk_req(2'h3, 1'h1);
        clk_req(2'h1, 1'h0);
        chk(cpuClkSrc, 2'h1);
        halt_check(1'h1);
        mem_read(3);
        for (int i = 0; i < 5; i++) begin
            bus(1'h1, 8'h04, {28'h0, i[0], i[1], i[1:0]});
            bus(1'h1, 8'h08, {24'h0, settleCode[i]});
            reset_pulse(1'h0);
            chk(extClockSelect, i[0]);
            chk(wakeupClockSelect, i[1]);
            chk(wakeupDivQuarter, divQ[i[1:0]]);
            chk(wakeupClockPrescale, i[1:0]);
            repeat (2) @(posedge core_clk);
            osc_pulses(settleN[i] - 1);
            @(posedge core_clk);
            chk(crystalStable, 1'h0);
            osc_pulses(1);
            @(posedge core_clk);
            chk(crystalStable, 1'h1);
            bus(1'h0, 8'h18, 32'h0);
            chk(rd[6], i == 4);
        end
        reset_pulse(1'h1);
        bus(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        wrap_up;
    end

    // A hung handshake or settle count ends the run here
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            wrap_up;
        end
    end
endmodule // test_obcd_option_decode
